// ===== core/ftm_top.v
// Fan tachometer monitor top: AXI4-Lite registers, events and interrupt.
//
// Function
// - Count divided reference over tach period, 8-bit
// - Reference from external pin or internal source
// - Tach rising edge restarts the count
// - Preload register write restarts the count
// - Restart loads the programmed preload value
// - Count saturates at 0xFF, never wraps
// - Both top count bits set flags slow fan
// - Slow fan drives wake/interrupt when enabled
// - Divide reference by 1, 2, 4, 8; default 2
// - Clock present bit is bit 0 at 0xF0
// - Divisor field is bits 5:4 of fan control
`timescale 1ns/100ps
`include "ftm_consts.vh"

module ftm_top #(
    parameter integer MCLK_HZ = `FTM_MCLK_HZ,   // System clock rate.
    parameter integer REF_HZ  = `FTM_REF_HZ     // Reference clock rate.
) (
    input  wire        MCLK_IN,          // System clock, 125 MHz.
    input  wire        RSTN_IN,          // Asynchronous reset, active low.
    input  wire        SLOW_CLK_IN,      // External slow reference clock.
    input  wire        TACH_IN,          // Tach_input_pin pulse input.
    output wire        WAKE_OUT,         // Wake event level, active high.
    output wire        SYSINT_OUT,       // Management interrupt level.
    output wire        IRQ_OUT,          // Masked status interrupt.
    input  wire [11:0] AWADDR_IN,        // Write address.
    input  wire        AWVALID_IN,       // Write address valid.
    output wire        AWREADY_OUT,      // Write address ready.
    input  wire [31:0] WDATA_IN,         // Write data.
    input  wire [3:0]  WSTRB_IN,         // Write byte strobes.
    input  wire        WVALID_IN,        // Write data valid.
    output wire        WREADY_OUT,       // Write data ready.
    output reg  [1:0]  BRESP_OUT,        // Write response.
    output reg         BVALID_OUT,       // Write response valid.
    input  wire        BREADY_IN,        // Write response ready.
    input  wire [11:0] ARADDR_IN,        // Read address.
    input  wire        ARVALID_IN,       // Read address valid.
    output wire        ARREADY_OUT,      // Read address ready.
    output reg  [31:0] RDATA_OUT,        // Read data.
    output reg  [1:0]  RRESP_OUT,        // Read response.
    output reg         RVALID_OUT,       // Read data valid.
    input  wire        RREADY_IN         // Read data ready.
);

    // ------------------------------------------------------------------
    // Reset release through two flip-flops.
    // ------------------------------------------------------------------
    reg rst_meta_q;  // First stage, read only by the second.
    reg rst_n_q;     // Synchronised reset used everywhere else.

    // Assertion is immediate; release waits two clock edges.
    always @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Register state.
    // ------------------------------------------------------------------
    reg  [7:0] preload_q;    // Starting value of the count.
    reg  [7:0] fan_ctrl_q;   // Fan control, divisor in bits 5:4.
    reg        clk_cfg_q;    // External slow clock present.
    reg        wake_en_q;    // Wake enable.
    reg        sysint_en_q;  // Management interrupt enable.
    reg  [1:0] int_stat_q;   // Sticky event status.
    reg  [1:0] int_mask_q;   // Status interrupt mask.
    reg        preload_wr_q; // One-cycle pulse after a preload write.
    reg        slow_prev_q;  // Slow flag of the previous cycle.
    reg        sat_prev_q;   // Saturation flag of the previous cycle.
    wire [7:0] count;        // Live count from the counter.
    wire       slow;         // Slow fan condition.
    wire       sat;          // Count at its ceiling.

    // ------------------------------------------------------------------
    // Counter instance.
    // ------------------------------------------------------------------
    ftm_counter #(
        .MCLK_HZ (MCLK_HZ),
        .REF_HZ  (REF_HZ)
    ) u_counter (
        .clk_in         (MCLK_IN),
        .rst_n_in       (rst_n_q),
        .ext_present_in (clk_cfg_q),
        .slow_clk_in    (SLOW_CLK_IN),
        .div_sel_in     (fan_ctrl_q[`FTM_DIV_HI:`FTM_DIV_LO]),
        .preload_in     (preload_q),
        .preload_wr_in  (preload_wr_q),
        .tach_in        (TACH_IN),
        .count_out      (count),
        .slow_out       (slow),
        .sat_out        (sat)
    );

    // Both outputs follow the live flag, so they fall again one cycle after a
    // tach edge restarts the count below the threshold.
    // Slow fan reaches the system outputs only through its enables. The
    // count is taken per tach pulse, which is half a revolution.
    assign WAKE_OUT   = slow & wake_en_q;
    assign SYSINT_OUT = slow & sysint_en_q;

    // ------------------------------------------------------------------
    // AXI4-Lite write channel.
    // ------------------------------------------------------------------
    reg        aw_got_q;  // Write address held.
    reg [11:0] aw_addr_q; // Held write address.
    reg        w_got_q;   // Write data held.
    reg [7:0]  w_data_q;  // Held low data byte.
    reg        w_strb_q;  // Held strobe of the low byte.

    assign AWREADY_OUT = ~aw_got_q & ~BVALID_OUT;
    assign WREADY_OUT  = ~w_got_q & ~BVALID_OUT;

    wire       wr_go  = aw_got_q & w_got_q & ~BVALID_OUT;
    wire [7:0] wr_idx = aw_addr_q[9:2];
    wire       wr_top = (aw_addr_q[11:10] == 2'h0);
    wire       wr_en  = wr_go & wr_top & w_strb_q;

    // Known registers accept the low byte; any other address answers
    // SLVERR so a stray access is visible to software.
    function wr_hit;
        input [7:0] idx;
        begin
            wr_hit = (idx == `FTM_IDX_TACH)      ||
                     (idx == `FTM_IDX_PRELOAD)   ||
                     (idx == `FTM_IDX_WAKE_EN)   ||
                     (idx == `FTM_IDX_SYSINT_EN) ||
                     (idx == `FTM_IDX_INT_STAT)  ||
                     (idx == `FTM_IDX_INT_MASK)  ||
                     (idx == `FTM_IDX_CLK_CFG)   ||
                     (idx == `FTM_IDX_FAN_CTRL);
        end
    endfunction

    // Address and data are taken in either order, then written together.
    always @(posedge MCLK_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            aw_got_q   <= 1'b0;
            aw_addr_q  <= 12'h000;
            w_got_q    <= 1'b0;
            w_data_q   <= 8'h00;
            w_strb_q   <= 1'b0;
            BVALID_OUT <= 1'b0;
            BRESP_OUT  <= `FTM_RESP_OKAY;
        end else begin
            if (AWVALID_IN && AWREADY_OUT) begin
                aw_got_q  <= 1'b1;
                aw_addr_q <= AWADDR_IN;
            end
            if (WVALID_IN && WREADY_OUT) begin
                w_got_q  <= 1'b1;
                w_data_q <= WDATA_IN[7:0];
                w_strb_q <= WSTRB_IN[0];
            end
            if (wr_go) begin
                aw_got_q   <= 1'b0;
                w_got_q    <= 1'b0;
                BVALID_OUT <= 1'b1;
                BRESP_OUT  <= (wr_top && wr_hit(wr_idx)) ?
                              `FTM_RESP_OKAY : `FTM_RESP_SLVERR;
            end else if (BVALID_OUT && BREADY_IN) begin
                BVALID_OUT <= 1'b0;
            end
        end
    end

    // Writable registers; the count itself is read-only.
    always @(posedge MCLK_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            preload_q    <= `FTM_PRELOAD_RST;
            fan_ctrl_q   <= `FTM_FAN_CTRL_RST;
            clk_cfg_q    <= 1'b0;
            wake_en_q    <= 1'b0;
            sysint_en_q  <= 1'b0;
            int_mask_q   <= 2'h0;
            preload_wr_q <= 1'b0;
        end else begin
            preload_wr_q <= wr_en && (wr_idx == `FTM_IDX_PRELOAD);
            if (wr_en) begin
                case (wr_idx)
                    `FTM_IDX_PRELOAD: begin
                        preload_q <= w_data_q;
                    end
                    `FTM_IDX_FAN_CTRL: begin
                        fan_ctrl_q <= w_data_q;
                    end
                    `FTM_IDX_CLK_CFG: begin
                        clk_cfg_q <= w_data_q[`FTM_CLK_PRESENT_BIT];
                    end
                    `FTM_IDX_WAKE_EN: begin
                        wake_en_q <= w_data_q[`FTM_EN_BIT];
                    end
                    `FTM_IDX_SYSINT_EN: begin
                        sysint_en_q <= w_data_q[`FTM_EN_BIT];
                    end
                    `FTM_IDX_INT_MASK: begin
                        int_mask_q <= w_data_q[1:0];
                    end
                    default: begin
                        preload_q <= preload_q;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel.
    // ------------------------------------------------------------------
    // One read at a time: the address channel stays closed while an
    // answer waits. This costs a cycle per read but ties each clearing
    // read of the status register to exactly one access.
    assign ARREADY_OUT = ~RVALID_OUT;

    wire       rd_take = ARVALID_IN & ARREADY_OUT;
    wire [7:0] rd_idx  = ARADDR_IN[9:2];
    wire       rd_top  = (ARADDR_IN[11:10] == 2'h0);
    reg  [7:0] rd_byte; // Selected register value.
    reg        rd_ok;   // Address maps to a register.

    // Register read mux; reserved bits read as zero.
    always @* begin
        rd_byte = 8'h00;
        rd_ok   = rd_top;
        case (rd_idx)
            `FTM_IDX_TACH:      rd_byte = count;
            `FTM_IDX_PRELOAD:   rd_byte = preload_q;
            `FTM_IDX_WAKE_EN:   rd_byte = {7'h00, wake_en_q};
            `FTM_IDX_SYSINT_EN: rd_byte = {7'h00, sysint_en_q};
            `FTM_IDX_INT_STAT:  rd_byte = {6'h00, int_stat_q};
            `FTM_IDX_INT_MASK:  rd_byte = {6'h00, int_mask_q};
            `FTM_IDX_CLK_CFG:   rd_byte = {7'h00, clk_cfg_q};
            `FTM_IDX_FAN_CTRL:  rd_byte = fan_ctrl_q;
            default:            rd_ok   = 1'b0;
        endcase
    end

    // Data are registered on acceptance and held until the master takes.
    always @(posedge MCLK_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            RVALID_OUT <= 1'b0;
            RDATA_OUT  <= 32'h00000000;
            RRESP_OUT  <= `FTM_RESP_OKAY;
        end else begin
            if (rd_take) begin
                RVALID_OUT <= 1'b1;
                RDATA_OUT  <= rd_ok ? {24'h000000, rd_byte} : 32'h00000000;
                RRESP_OUT  <= rd_ok ? `FTM_RESP_OKAY : `FTM_RESP_SLVERR;
            end else if (RVALID_OUT && RREADY_IN) begin
                RVALID_OUT <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sticky status, cleared by a read, and masked interrupt.
    // ------------------------------------------------------------------
    wire       stat_rd = rd_take & rd_top & (rd_idx == `FTM_IDX_INT_STAT);
    wire [1:0] ev_set;  // Event pulses, one bit per event.

    assign ev_set[`FTM_EV_SLOW] = slow & ~slow_prev_q;
    assign ev_set[`FTM_EV_SAT]  = sat & ~sat_prev_q;
    // The mask gates only the interrupt; status still records events,
    // so software may poll with the interrupt switched off.
    assign IRQ_OUT = |(int_stat_q & int_mask_q);

    always @(posedge MCLK_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            slow_prev_q <= 1'b0;
            sat_prev_q  <= 1'b0;
        end else begin
            slow_prev_q <= slow;
            sat_prev_q  <= sat;
        end
    end

    // A set in the same cycle as the clearing read survives, so an event
    // is never lost between read and clear.
    genvar gi;
    generate
        for (gi = 0; gi < `FTM_NUM_EV; gi = gi + 1) begin : g_stat
            always @(posedge MCLK_IN or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    int_stat_q[gi] <= 1'b0;
                end else if (ev_set[gi]) begin
                    int_stat_q[gi] <= 1'b1;
                end else if (stat_rd) begin
                    int_stat_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule // ftm_top

// ===== core/ftm_consts.vh
// Constants shared by the fan tachometer monitor design files.
`ifndef FTM_CONSTS_VH
`define FTM_CONSTS_VH

// ----------------------------------------------------------------------
// Bus geometry.
// ----------------------------------------------------------------------
`define FTM_ADDR_W        12
`define FTM_DATA_W        32

// ----------------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------------
`define FTM_IDX_TACH      8'h00
`define FTM_IDX_PRELOAD   8'h01
`define FTM_IDX_WAKE_EN   8'h02
`define FTM_IDX_SYSINT_EN 8'h03
`define FTM_IDX_INT_STAT  8'h04
`define FTM_IDX_INT_MASK  8'h05
`define FTM_IDX_CLK_CFG   8'hF0
`define FTM_IDX_FAN_CTRL  8'hFA

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define FTM_CLK_PRESENT_BIT 0
`define FTM_DIV_HI          5
`define FTM_DIV_LO          4
`define FTM_EN_BIT          0
`define FTM_EV_SLOW         0
`define FTM_EV_SAT          1
`define FTM_NUM_EV          2
`define FTM_FAN_CTRL_RST    8'h10
`define FTM_PRELOAD_RST     8'h00
`define FTM_CLK_CFG_RST     8'h00
`define FTM_CNT_MAX         8'hFF

// ----------------------------------------------------------------------
// Bus responses.
// ----------------------------------------------------------------------
`define FTM_RESP_OKAY     2'h0
`define FTM_RESP_SLVERR   2'h2

// ----------------------------------------------------------------------
// Timing: system clock and reference clock rates in hertz.
// ----------------------------------------------------------------------
`define FTM_MCLK_HZ       125000000
`define FTM_REF_HZ        32768

`endif

// ===== core/ftm_counter.v
// Reference clock selection, divider and saturating tach period counter.
`timescale 1ns/100ps
`include "ftm_consts.vh"

module ftm_counter #(
    parameter integer MCLK_HZ = `FTM_MCLK_HZ,   // System clock rate.
    parameter integer REF_HZ  = `FTM_REF_HZ     // Reference clock rate.
) (
    input  wire       clk_in,          // System clock.
    input  wire       rst_n_in,        // Synchronised reset, active low.
    input  wire       ext_present_in,  // External slow clock selected.
    input  wire       slow_clk_in,     // External slow clock level.
    input  wire [1:0] div_sel_in,      // Divisor code.
    input  wire [7:0] preload_in,      // Starting value of the count.
    input  wire       preload_wr_in,   // Pulse: preload was written.
    input  wire       tach_in,         // Tach_input_pin level.
    output reg  [7:0] count_out,       // Current count.
    output reg        slow_out,        // Two top count bits both set.
    output wire       sat_out          // Count has reached its ceiling.
);

    // ------------------------------------------------------------------
    // Internal reference: phase accumulator stepping REF_HZ per clock.
    // ------------------------------------------------------------------
    localparam [31:0] STEP_FULL = REF_HZ;  // Full-width increment.
    localparam [31:0] WRAP_FULL = MCLK_HZ; // Full-width wrap point.
    localparam [27:0] ACC_STEP = STEP_FULL[27:0]; // Increment per clock.
    localparam [27:0] ACC_WRAP = WRAP_FULL[27:0]; // Wrap point of the phase.

    reg  [27:0] acc_q;        // Phase of the internal reference.
    reg         slow_prev_q;  // Last level of the external clock.
    reg         tach_prev_q;  // Last level of the tach input.
    reg  [2:0]  pre_q;        // Divider prescale counter.
    wire [27:0] acc_sum = acc_q + ACC_STEP;
    wire        int_tick = (acc_sum >= ACC_WRAP);
    wire        ext_tick = slow_clk_in & ~slow_prev_q;
    wire        ref_tick = ext_present_in ? ext_tick : int_tick;
    wire        tach_rise = tach_in & ~tach_prev_q;
    wire [2:0]  pre_last = (3'h1 << div_sel_in) - 3'h1;
    wire        div_tick = ref_tick & (pre_q == pre_last);
    wire        restart = tach_rise | preload_wr_in;

    assign sat_out = (count_out == `FTM_CNT_MAX);

    // The phase accumulator keeps running so the internal reference
    // averages exactly REF_HZ; its jitter is one system clock.
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_q       <= 28'h0000000;
            slow_prev_q <= 1'b0;
            tach_prev_q <= 1'b0;
            pre_q       <= 3'h0;
        end else begin
            acc_q       <= int_tick ? (acc_sum - ACC_WRAP) : acc_sum;
            slow_prev_q <= slow_clk_in;
            tach_prev_q <= tach_in;
            // The prescaler also restarts so every period starts aligned.
            if (restart) begin
                pre_q <= 3'h0;
            end else if (ref_tick) begin
                pre_q <= (pre_q >= pre_last) ? 3'h0 : pre_q + 3'h1;
            end
        end
    end

    // Count divided reference ticks over one tach period, never wrapping.
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_out <= `FTM_PRELOAD_RST;
            slow_out  <= 1'b0;
        end else begin
            if (restart) begin
                count_out <= preload_in;
            end else if (div_tick && !sat_out) begin
                count_out <= count_out + 8'h01;
            end
            slow_out <= count_out[7] & count_out[6];
        end
    end

endmodule // ftm_counter

// ===== verification/ftm_checker.sv
// Checker for the register bus relations of the monitor top.
`timescale 1ns/100ps
`include "ftm_consts.vh"

module ftm_checker (
    input wire logic        MCLK_IN,     // System clock.
    input wire logic        RSTN_IN,     // Reset, active low.
    input wire logic [11:0] AWADDR_IN,   // Write address.
    input wire logic        AWVALID_IN,  // Write address valid.
    input wire logic        AWREADY_OUT, // Write address ready.
    input wire logic        WVALID_IN,   // Write data valid.
    input wire logic        WREADY_OUT,  // Write data ready.
    input wire logic [1:0]  BRESP_OUT,   // Write response.
    input wire logic        BVALID_OUT,  // Write response valid.
    input wire logic        BREADY_IN,   // Write response ready.
    input wire logic [11:0] ARADDR_IN,   // Read address.
    input wire logic        ARVALID_IN,  // Read address valid.
    input wire logic        ARREADY_OUT, // Read address ready.
    input wire logic [31:0] RDATA_OUT,   // Read data.
    input wire logic [1:0]  RRESP_OUT,   // Read response.
    input wire logic        RVALID_OUT,  // Read data valid.
    input wire logic        RREADY_IN,   // Read data ready.
    input wire logic        IRQ_OUT      // Interrupt level.
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RSTN_IN);

    // Remembers whether the last accepted write address was out of range.
    logic bad_wr_q;
    always @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            bad_wr_q <= 1'b0;
        end else if (AWVALID_IN && AWREADY_OUT) begin
            bad_wr_q <= (AWADDR_IN[11:10] != 2'h0);
        end
    end

    a_b_holds: assert property (
        BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
        else $error("write response dropped early");
    a_r_holds: assert property (
        RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
        else $error("read data dropped early");
    a_ar_refused: assert property (RVALID_OUT |-> !ARREADY_OUT)
        else $error("read address taken while answer pending");
    a_aw_refused: assert property (
        BVALID_OUT |-> !AWREADY_OUT && !WREADY_OUT)
        else $error("write taken while response pending");
    a_rd_answer: assert property (
        ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
        else $error("read answer late");
    a_wr_answer: assert property (
        AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT
        |-> ##[1:2] BVALID_OUT)
        else $error("write answer late");
    a_rd_unmapped: assert property (
        ARVALID_IN && ARREADY_OUT && ARADDR_IN[11:10] != 2'h0
        |=> RRESP_OUT == `FTM_RESP_SLVERR && RDATA_OUT == 32'h0)
        else $error("unmapped read not refused");
    a_wr_unmapped: assert property (
        BVALID_OUT && bad_wr_q |-> BRESP_OUT == `FTM_RESP_SLVERR)
        else $error("unmapped write not refused");

    c_write: cover property (BVALID_OUT && BREADY_IN);
    c_bad_read: cover property (RVALID_OUT && RRESP_OUT != 2'h0);
    c_irq: cover property ($rose(IRQ_OUT));
endmodule // ftm_checker

bind ftm_top ftm_checker ftm_checker_inst (.MCLK_IN, .RSTN_IN,
    .AWADDR_IN, .AWVALID_IN, .AWREADY_OUT, .WVALID_IN, .WREADY_OUT,
    .BRESP_OUT, .BVALID_OUT, .BREADY_IN, .ARADDR_IN, .ARVALID_IN,
    .ARREADY_OUT, .RDATA_OUT, .RRESP_OUT, .RVALID_OUT, .RREADY_IN,
    .IRQ_OUT);

// ===== verification/ftm_fan_model.sv
// Model of a fan whose tach output gives two pulses per turn.
`timescale 1ns/100ps

module ftm_fan_model #(
    parameter int REV_CYCLES = 400   // Clock cycles per revolution.
) (
    input  wire logic clk_in,   // System clock.
    input  wire logic run_in,   // Fan is spinning.
    output logic      tach_out  // Tach level, low while stopped.
);
    logic [15:0] cnt_q = 16'h0000;  // Position within one pulse period.
    // A stopped fan holds its tach low, so no restart can come from it.
    always @(posedge clk_in) begin
        if (!run_in || cnt_q >= 16'(REV_CYCLES / 2 - 1)) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
        tach_out <= run_in && (cnt_q < 16'(REV_CYCLES / 4));
    end
endmodule // ftm_fan_model

// ===== verification/ftm_tb_top.sv
// Testbench for the fan tachometer monitor registers and events.
`timescale 1ns/100ps
`include "ftm_consts.vh"

module ftm_tb_top;
    logic        clk = 1'b0;   // System clock, 125 MHz.
    logic        rstn = 1'b0;  // Reset, active low.
    logic        slow = 1'b0;  // External reference, 4 cycles a period.
    logic        run = 1'b0;   // Fan spinning.
    logic        tach;
    logic [11:0] awa = 12'h000;
    logic [11:0] ara = 12'h000;
    logic [31:0] wd = 32'h0;
    logic        awv = 1'b0;
    logic        wv = 1'b0;
    logic        br = 1'b0;
    logic        arv = 1'b0;
    logic        rr = 1'b0;
    logic        awrdy, wrdy, bvld, arrdy, rvld, wake, sint, irq;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, k;
    int          fails = 0;
    int          n_tests = 0;

    ftm_top ftm_top_inst (.MCLK_IN(clk), .RSTN_IN(rstn),
        .SLOW_CLK_IN(slow), .TACH_IN(tach), .WAKE_OUT(wake),
        .SYSINT_OUT(sint), .IRQ_OUT(irq), .AWADDR_IN(awa),
        .AWVALID_IN(awv), .AWREADY_OUT(awrdy), .WDATA_IN(wd),
        .WSTRB_IN(4'hF), .WVALID_IN(wv), .WREADY_OUT(wrdy),
        .BRESP_OUT(bresp), .BVALID_OUT(bvld), .BREADY_IN(br),
        .ARADDR_IN(ara), .ARVALID_IN(arv), .ARREADY_OUT(arrdy),
        .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvld),
        .RREADY_IN(rr));
    ftm_fan_model ftm_fan_model_inst (.clk_in(clk), .run_in(run),
        .tach_out(tach));

    always #4 clk = ~clk;
    // The reference toggles on clock edges so its phase is deterministic.
    always begin
        repeat (2) @(posedge clk);
        slow <= ~slow;
    end

    // ---------------------------------------------------------------
    // Bus tasks: each starts one edge after the last one ended, so no
    // handshake signal is written twice in one time step.
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] g, lo, hi);
        n_tests++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            fails++;
            $display("wrong value at %0t: %h not in %h..%h", $time, g, lo, hi);
        end
    endtask
    task automatic wrt(input logic [11:0] a, input logic [31:0] d);
        logic ha, hw, hb;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            @(negedge clk);
            ha = awv && awrdy;
            hw = wv && wrdy;
            hb = bvld;
            r = bresp;
            @(posedge clk);
            if (ha) awv <= 1'b0;
            if (hw) wv <= 1'b0;
        end
        br <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        wrt(a, d);
        chk({30'h0, r}, {30'h0, `FTM_RESP_OKAY}, {30'h0, `FTM_RESP_OKAY});
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] lo, hi,
                      input logic [1:0] er);
        logic ha, hr;
        logic [31:0] d;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        hr = 1'b0;
        while (!hr) begin
            @(negedge clk);
            ha = arv && arrdy;
            hr = rvld;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ha) arv <= 1'b0;
        end
        rr <= 1'b0;
        chk(d, lo, hi);
        chk({30'h0, r}, {30'h0, er}, {30'h0, er});
    endtask
    // Levels are looked at mid-cycle, after the edge's updates landed;
    // s picks the level: 0 interrupt, 1 wake, 2 management interrupt.
    task automatic lvl(input int s, input logic e);
        logic v;
        @(negedge clk);
        v = (s == 0) ? irq : (s == 1) ? wake : sint;
        chk({31'h0, v}, {31'h0, e}, {31'h0, e});
        @(posedge clk);
    endtask
    task automatic close_out;
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out;
    end

    // ---------------------------------------------------------------
    // Main sequence.
    // ---------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rc(12'h3E8, 32'h10, 32'h10, 2'h0);
        rc(12'h004, 32'h0, 32'h0, 2'h0);
        rc(12'h3C0, 32'h0, 32'h0, 2'h0);
        rc(12'h014, 32'h0, 32'h0, 2'h0);
        rc(12'h400, 32'h0, 32'h0, `FTM_RESP_SLVERR);
        wrt(12'h404, 32'h1);
        chk({30'h0, r}, 32'h2, 32'h2);
        // Internal reference ticks about once in 3815 cycles.
        wr(12'h004, 32'h10);
        repeat (400) @(posedge clk);
        rc(12'h000, 32'h10, 32'h11, 2'h0);
        wr(12'h3C0, 32'h1);
        for (k = 0; k < 4; k++) begin
            wr(12'h3E8, k << 4);
            rc(12'h3E8, k << 4, k << 4, 2'h0);
            wr(12'h004, 32'h0);
            repeat (400) @(posedge clk);
            rc(12'h000, (32'd100 >> k) - 2, (32'd100 >> k) + 3, 2'h0);
        end
        wr(12'h014, 32'h3);
        wr(12'h3E8, 32'h0);
        wr(12'h004, 32'hF0);
        repeat (200) @(posedge clk);
        rc(12'h000, 32'hFF, 32'hFF, 2'h0);
        lvl(0, 1'b1);
        rc(12'h010, 32'h3, 32'h3, 2'h0);
        lvl(0, 1'b0);
        rc(12'h010, 32'h0, 32'h0, 2'h0);
        wr(12'h3E8, 32'h30);
        wr(12'h008, 32'h1);
        wr(12'h004, 32'hBF);
        repeat (4) @(posedge clk);
        lvl(1, 1'b0);
        repeat (48) @(posedge clk);
        lvl(1, 1'b1);
        lvl(2, 1'b0);
        wr(12'h008, 32'h0);
        wr(12'h00C, 32'h1);
        lvl(1, 1'b0);
        lvl(2, 1'b1);
        // A spinning fan restarts the count every 200 cycles.
        wr(12'h3E8, 32'h0);
        wr(12'h004, 32'h20);
        run <= 1'b1;
        repeat (1000) @(posedge clk);
        rc(12'h000, 32'h20, 32'h20 + 32'd52, 2'h0);
        lvl(2, 1'b0);
        run <= 1'b0;
        repeat (1000) @(posedge clk);
        rc(12'h000, 32'hFF, 32'hFF, 2'h0);
        close_out;
    end
endmodule // ftm_tb_top
